// ==== logic/hrc_pkg.sv ====
// constants, types and encodings for the halt release controller
//
// Overview of operation
// (R01) halt instruction enters mode from mode field
// (R02) wake during light/stop entry held pending
// (R03) no pending hazard entering cpu-only halt
// (R04) new wake versus held: higher serviced first
// (R05) reset ends every halt mode
// (R06) reset keeps ram, reinitialises other settings
// (R07) interrupt wake keeps all settings unchanged
// (R08) enabled level wakes with interrupt processing
// (R09) masked ext0/rtc wake without handler, flag stays
// (R10) masked wake resumes after halt instruction
// (R11) stop wake acts only after warm-up
// (R12) nonmaskable level fixed at seven
// (R13) level ext0 source holds until processing
// (R14) software sets timer halt-run for ext5/6
// (R15) cpu-only halt: cpu stops, enabled peripherals run
// (R16) light-sleep: oscillator, rtc run; sysclk stopped
// (R17) wake sampled async, resume on sysclk
// (R18) stop halts oscillator; pins follow drive bit
// (R19) no system clock until warm-up elapsed
// (R20) release clock chosen by select and enables
// (R21) warm-up 2^8, 2^14, 2^16 oscillator periods
// (R22) external reset held for oscillator stabilising
// (R23) warm-up counter cleared, counts to terminal
package hrc_pkg;

  typedef logic [2:0] hrc_lvl_t;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] HRC_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] HRC_ADDR_STATUS = 12'h004;

  localparam int HRC_CTRL_W        = 9;
  localparam int HRC_F_HALT_MODE   = 0;
  localparam int HRC_F_WARM_LEN    = 2;
  localparam int HRC_F_REL_SLOW    = 4;
  localparam int HRC_F_FAST_EN     = 5;
  localparam int HRC_F_SLOW_EN     = 6;
  localparam int HRC_F_PIN_DRIVE   = 7;
  localparam int HRC_F_TIMERB_RUN  = 8;
  localparam logic [8:0] HRC_CTRL_RST = 9'h02F;

  localparam int HRC_F_ST_STATE = 0;
  localparam int HRC_F_ST_PEND  = 4;
  localparam int HRC_F_ST_BUSY  = 10;

  // ---------------------------------------------------------------
  // modes, sources and timing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HRC_MODE_NONE  = 2'b00,
    HRC_MODE_STOP  = 2'b01,
    HRC_MODE_LIGHT = 2'b10,
    HRC_MODE_CPU   = 2'b11
  } hrc_mode_e;

  typedef enum logic [3:0] {
    HRC_ST_RUN      = 4'h0,
    HRC_ST_ENTRY    = 4'h1,
    HRC_ST_CPU_HALT = 4'h2,
    HRC_ST_LIGHT    = 4'h3,
    HRC_ST_STOP     = 4'h4,
    HRC_ST_WARMUP   = 4'h5,
    HRC_ST_DISPATCH = 4'h6,
    HRC_ST_SECOND   = 4'h7
  } hrc_state_e;

  // source index: 0 nmi, 1 watchdog, 2 ext0, 3 rtc, 4 ext5/6, 5 internal peripherals
  localparam int HRC_NSRC = 6;
  localparam int HRC_NPIN = 5;
  localparam hrc_lvl_t HRC_NMI_LEVEL = 3'h7;

  localparam logic [5:0] HRC_TAKE_CPU   = 6'h3F;
  localparam logic [5:0] HRC_TAKE_LIGHT = 6'h0D;
  localparam logic [5:0] HRC_TAKE_STOP  = 6'h05;
  localparam logic [5:0] HRC_RES_LIGHT  = 6'h0C;
  localparam logic [5:0] HRC_RES_STOP   = 6'h04;
  localparam logic [5:0] HRC_PEND_OK    = 6'h0D;
  localparam logic [5:0] HRC_SRC_EXT56  = 6'h10;

  localparam logic [2:0] HRC_ENTRY_TICKS = 3'h5;

  localparam int HRC_WARM_W = 17;
  localparam logic [16:0] HRC_WARM_SHORT = 17'h00100;
  localparam logic [16:0] HRC_WARM_MID   = 17'h04000;
  localparam logic [16:0] HRC_WARM_LONG  = 17'h10000;

endpackage

// ==== logic/hrc_warm_if.sv ====
// link between the release controller and its warm-up counter
`timescale 1ns/1ps
`default_nettype none
interface hrc_warm_if;
  logic       start;
  logic       osc_tick;
  logic [1:0] len_sel;
  logic       done;
  logic       busy;

  modport ctrl (output start, output osc_tick, output len_sel, input done, input busy);
  modport cnt  (input start, input osc_tick, input len_sel, output done, output busy);
endinterface
`default_nettype wire

// ==== logic/hrc_warmup.sv ====
// oscillator warm-up counter used after a full stop
`timescale 1ns/1ps
`default_nettype none
module hrc_warmup
  import hrc_pkg::*;
#(
  parameter logic [16:0] WARM_SHORT = HRC_WARM_SHORT,
  parameter logic [16:0] WARM_MID   = HRC_WARM_MID,
  parameter logic [16:0] WARM_LONG  = HRC_WARM_LONG
)(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  hrc_warm_if.cnt   w
);

  typedef struct packed {
    logic [16:0] count;
    logic        busy;
    logic        done;
  } hrc_warm_s;

  hrc_warm_s   q;
  hrc_warm_s   d;
  logic [16:0] term;

  always_comb
  begin
    // code 00 has no defined length; it falls back to the shortest one
    unique case (w.len_sel)
      2'b10:   term = WARM_MID;
      2'b11:   term = WARM_LONG;
      default: term = WARM_SHORT;
    endcase
    d = q;
    d.done = 1'b0;
    if (w.start)
    begin
      d.count = '0; // R23
      d.busy  = 1'b1;
    end
    else if (q.busy && w.osc_tick)
    begin
      if (q.count == term - 17'h00001) // R21
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.count = q.count + 17'h00001; // R23
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign w.done = q.done;
  assign w.busy = q.busy;

endmodule
`default_nettype wire

// ==== logic/hrc_top.sv ====
// halt release controller: halt entry, wake decision, warm-up and dispatch
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hrc_top
#(
  parameter logic [16:0] WARM_SHORT = hrc_pkg::HRC_WARM_SHORT,
  parameter logic [16:0] WARM_MID   = hrc_pkg::HRC_WARM_MID,
  parameter logic [16:0] WARM_LONG  = hrc_pkg::HRC_WARM_LONG
)(
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // apb slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [11:0]      i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  // cpu side
  input  wire logic             i_halt_exec,
  input  wire hrc_pkg::hrc_lvl_t i_interrupt_mask_level,
  input  wire logic             i_prescaler_clock,
  input  wire logic             i_fast_osc_tick,
  input  wire logic             i_slow_osc_tick,
  // wake sources: pins are asynchronous, the peripheral request is on i_mclk
  input  wire logic             i_nmi_req,
  input  wire logic             i_watchdog_irq,
  input  wire logic             i_ext_irq_zero,
  input  wire logic             i_rtc_wake_irq,
  input  wire logic             i_ext_irq_five_six,
  input  wire logic             i_periph_irq,
  input  wire hrc_pkg::hrc_lvl_t i_watchdog_level,
  input  wire hrc_pkg::hrc_lvl_t i_ext_zero_level,
  input  wire hrc_pkg::hrc_lvl_t i_rtc_level,
  input  wire hrc_pkg::hrc_lvl_t i_ext_five_six_level,
  input  wire hrc_pkg::hrc_lvl_t i_periph_level,
  // outcomes
  output logic                  o_irq_take,
  output logic [2:0]            o_irq_src,
  output logic                  o_resume,
  output logic                  o_cpu_run,
  output logic                  o_halted,
  output logic                  o_sysclk_en,
  output logic                  o_halt_run_only,
  output logic                  o_timerb_clk_en,
  output logic                  o_osc_run,
  output logic                  o_rtc_run,
  output logic                  o_fast_osc_en,
  output logic                  o_slow_osc_en,
  output logic                  o_release_clk_slow,
  output logic                  o_stop_pin_drive
);
  import hrc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    hrc_state_e       state;
    logic [2:0]       entry_cnt;
    logic [5:0]       pend;
    logic             first_take;
    logic [2:0]       first_id;
    logic             second_valid;
    logic [2:0]       second_id;
    logic [8:0]       ctrl;
    logic [31:0]      prdata;
    logic             take;
    logic [2:0]       irq_id;
    logic             resume;
    logic [4:0]       sync1;
    logic [4:0]       sync2;
  } hrc_state_s;

  hrc_state_s q;
  hrc_state_s d;

  hrc_warm_if w ();

  hrc_warmup #(
    .WARM_SHORT (WARM_SHORT),
    .WARM_MID   (WARM_MID),
    .WARM_LONG  (WARM_LONG)
  ) u_warmup (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .w       (w)
  );

  // ---------------------------------------------------------------
  // per-source eligibility
  // ---------------------------------------------------------------
  logic [5:0] req;
  logic [5:0] en;
  logic [5:0] allow_take;
  logic [5:0] allow_res;
  logic [5:0] take_ok;
  logic [5:0] res_ok;
  hrc_lvl_t   lvl [HRC_NSRC];
  logic       start_c;

  // pins only reach the decision logic through the second flop
  assign req = {i_periph_irq, q.sync2}; // R17

  assign lvl[0] = HRC_NMI_LEVEL; // R12
  assign lvl[1] = i_watchdog_level;
  assign lvl[2] = i_ext_zero_level;
  assign lvl[3] = i_rtc_level;
  assign lvl[4] = i_ext_five_six_level;
  assign lvl[5] = i_periph_level;

  always_comb
  begin
    unique case (q.state)
      HRC_ST_CPU_HALT:
      begin
        // ext5/6 pass through the 16-bit timer, which only runs here with its halt-run bit
        allow_take = HRC_TAKE_CPU & ~(HRC_SRC_EXT56 & {6{~q.ctrl[HRC_F_TIMERB_RUN]}}); // R14
        allow_res  = HRC_RES_LIGHT; // R09
      end
      HRC_ST_LIGHT:
      begin
        allow_take = HRC_TAKE_LIGHT; // R08
        allow_res  = HRC_RES_LIGHT; // R09
      end
      HRC_ST_STOP:
      begin
        allow_take = HRC_TAKE_STOP; // R08
        allow_res  = HRC_RES_STOP; // R09
      end
      default:
      begin
        allow_take = '0;
        allow_res  = '0;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < HRC_NSRC; gi++)
    begin : g_src
      assign en[gi]      = (lvl[gi] >= i_interrupt_mask_level); // R08
      assign take_ok[gi] = req[gi] & ~q.pend[gi] & en[gi] & allow_take[gi];
      assign res_ok[gi]  = req[gi] & ~q.pend[gi] & ~en[gi] & allow_res[gi]; // R09
    end
  endgenerate

  // ---------------------------------------------------------------
  // priority pick among new and held requests
  // ---------------------------------------------------------------
  logic       new_valid;
  logic [2:0] new_id;
  logic       pend_valid;
  logic [2:0] pend_id;

  always_comb
  begin
    new_valid  = 1'b0;
    new_id     = '0;
    pend_valid = 1'b0;
    pend_id    = '0;
    // ties go to the lower source index
    for (int i = HRC_NSRC - 1; i >= 0; i--)
    begin
      if (take_ok[i] && (!new_valid || lvl[i] >= lvl[new_id]))
      begin
        new_valid = 1'b1;
        new_id    = i[2:0];
      end
      if (q.pend[i] && en[i] && (!pend_valid || lvl[i] >= lvl[pend_id]))
      begin
        pend_valid = 1'b1;
        pend_id    = i[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic mapped;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign mapped    = (i_paddr == HRC_ADDR_CTRL) || (i_paddr == HRC_ADDR_STATUS);

  always_comb
  begin
    d        = q;
    d.take   = 1'b0;
    d.resume = 1'b0;
    start_c  = 1'b0;
    d.sync1  = {i_ext_irq_five_six, i_rtc_wake_irq, i_ext_irq_zero, i_watchdog_irq, i_nmi_req};
    d.sync2  = q.sync1;

    if (apb_wr && i_paddr == HRC_ADDR_CTRL)
      d.ctrl = i_pwdata[HRC_CTRL_W-1:0];
    if (apb_setup)
    begin
      d.prdata = '0;
      if (i_paddr == HRC_ADDR_CTRL)
        d.prdata[HRC_CTRL_W-1:0] = q.ctrl;
      else if (i_paddr == HRC_ADDR_STATUS)
      begin
        d.prdata[HRC_F_ST_STATE +: 4] = q.state;
        d.prdata[HRC_F_ST_PEND +: 6]  = q.pend;
        d.prdata[HRC_F_ST_BUSY]       = w.busy;
      end
    end

    unique case (q.state)
      HRC_ST_RUN:
      begin
        if (i_halt_exec)
        begin
          d.entry_cnt = '0;
          unique case (hrc_mode_e'(q.ctrl[HRC_F_HALT_MODE +: 2])) // R01
            HRC_MODE_CPU:   d.state = HRC_ST_CPU_HALT; // R03
            HRC_MODE_LIGHT: d.state = HRC_ST_ENTRY;
            HRC_MODE_STOP:  d.state = HRC_ST_ENTRY;
            HRC_MODE_NONE:  d.state = HRC_ST_RUN;
          endcase
        end
      end
      HRC_ST_ENTRY:
      begin
        // requests seen during entry cannot wake; nmi, ext0 and rtc ones are parked, the others are dropped
        d.pend = q.pend | (req & HRC_PEND_OK); // R02
        if (i_prescaler_clock)
        begin
          d.entry_cnt = q.entry_cnt + 3'h1;
          if (q.entry_cnt == HRC_ENTRY_TICKS - 3'h1)
          begin
            if (q.ctrl[HRC_F_HALT_MODE +: 2] == HRC_MODE_STOP)
              d.state = HRC_ST_STOP;
            else
              d.state = HRC_ST_LIGHT;
          end
        end
      end
      HRC_ST_CPU_HALT, HRC_ST_LIGHT, HRC_ST_STOP:
      begin
        if (new_valid || (|res_ok))
        begin
          d.pend         = '0;
          d.second_valid = pend_valid;
          d.second_id    = pend_id;
          if (new_valid)
          begin
            d.first_take = 1'b1; // R08
            if (pend_valid && lvl[pend_id] > lvl[new_id]) // R04
            begin
              d.first_id  = pend_id;
              d.second_id = new_id;
            end
            else
              d.first_id = new_id;
          end
          else
          begin
            d.first_take = 1'b0; // R10
            d.first_id   = '0;
          end
          if (q.state == HRC_ST_STOP)
          begin
            start_c = 1'b1; // R11
            d.state = HRC_ST_WARMUP;
          end
          else
            d.state = HRC_ST_DISPATCH; // R17
        end
      end
      HRC_ST_WARMUP:
      begin
        if (w.done)
          d.state = HRC_ST_DISPATCH; // R11
      end
      HRC_ST_DISPATCH:
      begin
        // nothing in ctrl is touched on a wake, so settings stay as before the halt
        d.take   = q.first_take; // R07
        d.irq_id = q.first_id;
        d.resume = ~q.first_take; // R10
        d.state  = q.second_valid ? HRC_ST_SECOND : HRC_ST_RUN;
      end
      HRC_ST_SECOND:
      begin
        d.take   = 1'b1; // R04
        d.irq_id = q.second_id;
        d.state  = HRC_ST_RUN;
      end
      default:
        d.state = HRC_ST_RUN;
    endcase
  end

  // reset only clears this block; ram keeps its contents through it
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q       <= '0; // R05
      q.ctrl  <= HRC_CTRL_RST; // R06
      q.state <= HRC_ST_RUN; // R05
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign w.start    = start_c;
  assign w.len_sel  = q.ctrl[HRC_F_WARM_LEN +: 2]; // R21
  assign w.osc_tick = q.ctrl[HRC_F_REL_SLOW] ? i_slow_osc_tick : i_fast_osc_tick; // R20

  assign o_prdata  = q.prdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  assign o_irq_take = q.take;
  assign o_irq_src  = q.irq_id;
  assign o_resume   = q.resume;

  assign o_cpu_run       = (q.state == HRC_ST_RUN); // R15
  assign o_halted        = (q.state != HRC_ST_RUN);
  assign o_halt_run_only = (q.state == HRC_ST_CPU_HALT); // R15
  assign o_timerb_clk_en = o_sysclk_en & (~o_halt_run_only | q.ctrl[HRC_F_TIMERB_RUN]); // R15
  assign o_sysclk_en     = (q.state != HRC_ST_LIGHT) && (q.state != HRC_ST_STOP) &&
                           (q.state != HRC_ST_WARMUP); // R16 R19
  assign o_osc_run       = (q.state != HRC_ST_STOP); // R16 R18
  assign o_rtc_run       = (q.state != HRC_ST_STOP); // R16
  assign o_fast_osc_en   = o_osc_run & q.ctrl[HRC_F_FAST_EN]; // R20
  assign o_slow_osc_en   = o_osc_run & q.ctrl[HRC_F_SLOW_EN]; // R20
  assign o_release_clk_slow = q.ctrl[HRC_F_REL_SLOW]; // R20
  assign o_stop_pin_drive   = (q.state == HRC_ST_STOP) & q.ctrl[HRC_F_PIN_DRIVE]; // R18

endmodule
`default_nettype wire

// ==== tb/hrc_clkgen_model.sv ====
// behavioural model of the clock generator feeding the controller
`timescale 1ns/1ps
`default_nettype none
module hrc_clkgen_model (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_fast_osc_en,
  input  wire logic i_slow_osc_en,
  output logic      o_prescaler_clock,
  output logic      o_fast_osc_tick,
  output logic      o_slow_osc_tick
);
  logic [2:0] div_q;

  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // a stopped oscillator yields no periods, so warm-up cannot run early
  assign o_prescaler_clock = i_fast_osc_en && (div_q[1:0] == 2'h3);
  assign o_fast_osc_tick   = i_fast_osc_en && div_q[0];
  assign o_slow_osc_tick   = i_slow_osc_en && (div_q == 3'h7);
endmodule
`default_nettype wire

// ==== tb/hrc_checker.sv ====
// concurrent checks on the halt release controller ports
`timescale 1ns/1ps
`default_nettype none
module hrc_checker (
  input wire logic             i_mclk,
  input wire logic             i_rst_n,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic             i_periph_irq,
  input wire hrc_pkg::hrc_lvl_t i_periph_level,
  input wire hrc_pkg::hrc_lvl_t i_interrupt_mask_level,
  input wire logic             o_pready,
  input wire logic             o_irq_take,
  input wire logic             o_resume,
  input wire logic             o_cpu_run,
  input wire logic             o_halted,
  input wire logic             o_sysclk_en,
  input wire logic             o_halt_run_only,
  input wire logic             o_osc_run,
  input wire logic             o_rtc_run,
  input wire logic             o_fast_osc_en,
  input wire logic             o_slow_osc_en,
  input wire logic             o_stop_pin_drive
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_pready_zero_wait: assert property (i_psel && i_penable |-> o_pready) else $error("pready low");
  a_halt_decode: assert property (o_halted != o_cpu_run) else $error("halted and run disagree");
  // with a held request queued, run state follows one cycle later together with its take
  a_take_runs_cpu: assert property (o_irq_take |-> o_sysclk_en and
    (o_cpu_run or ##1 (o_cpu_run && o_irq_take))) else $error("take off run");
  a_resume_single: assert property (o_resume |-> !o_irq_take and
    (o_cpu_run or ##1 (o_cpu_run && o_irq_take)) and ##1 !o_resume) else $error("resume");
  a_periph_cpu_wake: assert property (
    o_halt_run_only && i_periph_irq && (i_periph_level >= i_interrupt_mask_level)
    |-> ##1 !o_halt_run_only ##1 o_irq_take) else $error("periph wake late");
  a_stop_osc_off: assert property (
    !o_osc_run |-> !o_sysclk_en && !o_fast_osc_en && !o_slow_osc_en) else $error("clock alive in stop");
  a_rtc_with_osc: assert property (o_rtc_run == o_osc_run) else $error("rtc and osc differ");
  a_warm_no_clk: assert property ($rose(o_osc_run) |-> !o_sysclk_en) else $error("clock before warm-up");
  a_cpu_halt_clk: assert property (o_halt_run_only |-> o_sysclk_en && o_halted) else $error("cpu halt clock");
  a_pin_drive_stop: assert property (o_stop_pin_drive |-> !o_osc_run) else $error("pin drive off stop");
  a_reset_runs: assert property ($rose(i_rst_n) |-> o_cpu_run && o_sysclk_en) else $error("not running");
endmodule

bind hrc_top hrc_checker chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_periph_irq(i_periph_irq), .i_periph_level(i_periph_level), .i_interrupt_mask_level(i_interrupt_mask_level),
  .o_pready(o_pready), .o_irq_take(o_irq_take), .o_resume(o_resume), .o_cpu_run(o_cpu_run), .o_halted(o_halted),
  .o_sysclk_en(o_sysclk_en), .o_halt_run_only(o_halt_run_only), .o_osc_run(o_osc_run), .o_rtc_run(o_rtc_run),
  .o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en), .o_stop_pin_drive(o_stop_pin_drive));
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the halt release controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hrc_pkg::*;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, halt = 0, periph = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, take, resume, cpu_run, halted, sysclk_en, hro, osc_run, fast_en, slow_en;
  logic        pre, ftk, stk;
  logic        tbe, rslow;
  logic [2:0]  src, mask = '0;
  logic [4:0]  pin = '0;
  logic [2:0]  lvl [6] = '{default: 3'h0};
  int          fail_count = 0, num_checks = 0;

  always #5 mclk = ~mclk;

  hrc_top #(.WARM_SHORT(17'h4), .WARM_MID(17'h8), .WARM_LONG(17'h10)) dut_u (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_halt_exec(halt), .i_interrupt_mask_level(mask), .i_prescaler_clock(pre), .i_fast_osc_tick(ftk),
    .i_slow_osc_tick(stk), .i_nmi_req(pin[0]), .i_watchdog_irq(pin[1]), .i_ext_irq_zero(pin[2]),
    .i_rtc_wake_irq(pin[3]), .i_ext_irq_five_six(pin[4]), .i_periph_irq(periph), .i_watchdog_level(lvl[1]),
    .i_ext_zero_level(lvl[2]), .i_rtc_level(lvl[3]), .i_ext_five_six_level(lvl[4]), .i_periph_level(lvl[5]),
    .o_irq_take(take), .o_irq_src(src), .o_resume(resume), .o_cpu_run(cpu_run), .o_halted(halted),
    .o_sysclk_en(sysclk_en), .o_halt_run_only(hro), .o_timerb_clk_en(tbe), .o_osc_run(osc_run), .o_rtc_run(),
    .o_fast_osc_en(fast_en), .o_slow_osc_en(slow_en), .o_release_clk_slow(rslow), .o_stop_pin_drive());

  hrc_clkgen_model clk_u (.i_mclk(mclk), .i_rst_n(rst_n), .i_fast_osc_en(fast_en), .i_slow_osc_en(slow_en),
    .o_prescaler_clock(pre), .o_fast_osc_tick(ftk), .o_slow_osc_tick(stk));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a wait that used up its bound ends the run as a failure
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      print_verdict;
    end
  endtask

  // zero wait is expected, but the master never assumes it
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    check("apb ready", n < 50, 1);
    bound(n, 50);
    check("apb error", pslverr, (a != HRC_ADDR_CTRL) && (a != HRC_ADDR_STATUS));
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_out(input int lim, output int code, output int n);
    code = 0;
    for (n = 0; n < lim && code == 0; n++)
    begin
      @(negedge mclk);
      code = (take === 1'b1) ? 1 : (resume === 1'b1) ? 2 : 0;
    end
  endtask

  function automatic int exp_wake(int m, int s, int l, int k, int t);
    bit en;
    en = (s == 0) || (l >= k);
    if (en)
      return ((m == 3 && (s != 4 || t != 0)) || s == 0 || s == 2 || (s == 3 && m == 2)) ? 1 : 0;
    return (s == 2 || (s == 3 && m != 1)) ? 2 : 0;
  endfunction

  task automatic req(int s, logic v);
    @(posedge mclk);
    if (s == 5) periph <= v;
    else pin[s] <= v;
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    print_verdict;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int m, s, ws, l, k, e, code, n, rs, tr, wt;
    logic [31:0] rd, ctl;
    void'($urandom(7));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, HRC_ADDR_CTRL, 0, rd);
    check("ctrl reset", rd, {23'h0, HRC_CTRL_RST});
    apb(0, 12'h008, 0, rd);
    check("unmapped read", rd, 0);
    for (int i = 0; i < 30; i++)
    begin
      m = 1 + $urandom % 3; s = $urandom % 6; ws = 1 + $urandom % 3; l = $urandom % 8; k = $urandom % 8;
      rs = $urandom % 2;
      tr = $urandom % 2;
      ctl = m | (ws << HRC_F_WARM_LEN) | (tr << HRC_F_TIMERB_RUN) | 32'h20;
      ctl = ctl | (rs << HRC_F_REL_SLOW) | (rs << HRC_F_SLOW_EN);
      @(posedge mclk);
      mask <= k[2:0];
      lvl[s] <= l[2:0];
      apb(1, HRC_ADDR_CTRL, ctl, rd);
      apb(0, HRC_ADDR_CTRL, 0, rd);
      check("ctrl readback", rd, ctl);
      @(posedge mclk) halt <= 1'b1;
      @(posedge mclk) halt <= 1'b0;
      n = 0;
      do begin @(negedge mclk); n++; end while (!(m == 3 ? hro : !sysclk_en) && n < 100);
      bound(n, 100);
      // halted, cpu-only, oscillator, system clock, timer clock
      e = (m == 3) ? (32'h1E | tr) : (m == 2) ? 32'h14 : 32'h10;
      check("halt outputs", {halted, hro, osc_run, sysclk_en, tbe}, e);
      check("release clock", rslow, rs);
      req(s, 1'b1);
      wait_out(300, code, n);
      e = exp_wake(m, s, l, k, tr);
      check("wake kind", code, e);
      if (e == 1) check("wake source", src, s);
      // the slow oscillator ticks every 8 cycles in the clock model, the fast one every 2
      wt = (rs != 0 ? 8 : 2) * (4 << (ws - 1));
      if (m == 1 && e != 0) check("warm-up span", n > wt - 8 && n <= wt + 12, 1);
      req(s, 1'b0);
      if (code == 0)
      begin
        @(posedge mclk) rst_n <= 1'b0;
        @(posedge mclk) rst_n <= 1'b1;
        @(negedge mclk) check("reset ends halt", cpu_run, 1);
      end
    end
    @(posedge mclk);
    mask <= 3'h1; lvl[3] <= 3'h2; lvl[2] <= 3'h5;
    apb(1, HRC_ADDR_CTRL, 32'h126, rd);
    @(posedge mclk) halt <= 1'b1;
    @(posedge mclk) halt <= 1'b0;
    pin[3] <= 1'b1;
    repeat (4) @(posedge mclk);
    pin[3] <= 1'b0;
    n = 0;
    do begin @(negedge mclk); n++; end while (sysclk_en !== 1'b0 && n < 100);
    bound(n, 100);
    repeat (10) @(negedge mclk);
    check("held request stays asleep", {halted, sysclk_en}, 2'b10);
    apb(0, HRC_ADDR_STATUS, 0, rd);
    check("held status", rd, (32'h8 << HRC_F_ST_PEND) | HRC_ST_LIGHT);
    req(2, 1'b1);
    wait_out(300, code, n);
    check("first of two", {code[1:0], src}, {2'h1, 3'h2});
    @(negedge mclk) check("second of two", {take, src}, {1'b1, 3'h3});
    req(2, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
